// ==== urmd_pkg.sv ====
package urmd_pkg;
  localparam logic [3:0] URMD_OFS_HOLD = 4'h0;
  localparam logic [3:0] URMD_OFS_MASK = 4'h1;
  localparam logic [3:0] URMD_OFS_FEAT = 4'h2;
  localparam logic [3:0] URMD_OFS_LINE = 4'h3;
  localparam logic [3:0] URMD_OFS_MODEM = 4'h4;
  localparam logic [3:0] URMD_OFS_RES1 = 4'h5;
  localparam logic [3:0] URMD_OFS_PAUSE1 = 4'h6;
  localparam logic [3:0] URMD_OFS_PAUSE2 = 4'h7;
  localparam logic [3:0] URMD_OFS_GPLVL = 4'hb;
  localparam logic [3:0] URMD_OFS_GPMSK = 4'hc;
  localparam logic [3:0] URMD_OFS_RSVD = 4'hd;
  localparam logic [3:0] URMD_OFS_PINCTL = 4'he;
  localparam logic [3:0] URMD_OFS_EXTRA = 4'hf;
  localparam logic [7:0] URMD_LINE_ENH_KEY = 8'hbf;
  localparam int URMD_LINE_DIV_BIT = 7;
  localparam int URMD_FEAT_ENH_BIT = 4;
  localparam int URMD_PINCTL_SWRST_BIT = 3;
  localparam logic [7:0] URMD_PINCTL_MASK = 8'h07;
  localparam logic [7:0] URMD_EXTRA_MASK = 8'hb7;
  localparam logic [7:0] URMD_MASK_ENH = 8'hf0;
  localparam logic [7:0] URMD_QCTL_ENH = 8'h30;
  localparam logic [7:0] URMD_MODEM_ENH = 8'he0;
  localparam logic [7:0] URMD_ISR_NONE = 8'h01;
  localparam logic [7:0] URMD_RST_ZERO = 8'h00;
  localparam logic [7:0] URMD_RST_LINE = 8'h1d;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } urmd_req_s;

  typedef struct packed {
    logic rx_ready;
    logic tx_empty;
    logic line_err;
    logic modem_chg;
  } urmd_src_s;

  typedef enum logic [2:0] {
    URMD_MAP_PLAIN,
    URMD_MAP_DIVISOR,
    URMD_MAP_ENHANCED
  } urmd_map_e;
endpackage

// ==== urmd_regs.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] Enhanced-only bits writable only with feature bit4
// [RULE_02] Mask gates four interrupt sources individually
// [RULE_03] Offset 0 read returns received character
// [RULE_04] Offset 0 write loads transmit character
// [RULE_05] Divisor latch replaces offsets 0,1 when selected
// [RULE_06] Feature register fields: cts, rts, special, enhanced
// [RULE_07] Enhanced map only when line control is 0xBF
// [RULE_08] Software reset bit clears core; reserved reads zero
module urmd_regs (
  input wire logic clk,
  input wire logic reset,
  input wire urmd_pkg::urmd_req_s req,
  output logic [7:0] rdata,
  input wire logic [7:0] rx_char,
  output logic rx_pop,
  output logic [7:0] tx_char,
  output logic tx_load,
  input wire urmd_pkg::urmd_src_s src,
  output logic [7:0] irq_status,
  output logic irq_n,
  output logic [15:0] divisor,
  output logic [7:0] frac_divisor,
  output logic [7:0] feature,
  output logic [7:0] line_control,
  output logic [7:0] irq_mask,
  output logic [7:0] queue_control,
  output logic [7:0] modem_line_control,
  output logic [31:0] flow_chars,
  output logic [7:0] gp_level_out,
  input wire logic [7:0] gp_level_in,
  output logic [7:0] gp_irq_mask,
  output logic [7:0] pin_control,
  output logic [7:0] extra_control,
  output logic core_reset
);
  import urmd_pkg::*;

  logic [7:0] div_lo_r, div_hi_r, frac_r, feat_r, line_r, mask_r;
  logic [7:0] qctl_r, modem_r, res1_r, res2_r, pause1_r, pause2_r;
  logic [7:0] gplvl_r, gpmsk_r, pinctl_r, extra_r, tx_r;
  logic tx_load_r, rx_pop_r, core_reset_r;
  logic [7:0] rdata_nxt, rdata_r;

  // Locked bits keep their old value instead of clearing, so a legacy
  // driver that writes zeros there cannot undo an enhanced setup
  function automatic logic [7:0] urmd_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] enh_bits,
                                            input logic enh);
    urmd_merge = enh ? new_v : ((old_v & enh_bits) | (new_v & ~enh_bits));
  endfunction

  // 0xbf also has bit 7 set, so the key test must win over the divisor
  // test or the feature register at offset 2 would never be reachable
  urmd_map_e map;
  wire line_is_key = (line_r == URMD_LINE_ENH_KEY);
  wire div_sel = line_r[URMD_LINE_DIV_BIT] && !line_is_key; // [RULE_05]
  wire enh_on = feat_r[URMD_FEAT_ENH_BIT]; // [RULE_01]
  assign map = line_is_key ? URMD_MAP_ENHANCED : // [RULE_07]
               (div_sel ? URMD_MAP_DIVISOR : URMD_MAP_PLAIN);

  wire wr_hold = req.wr && req.addr == URMD_OFS_HOLD;
  wire wr_mask = req.wr && req.addr == URMD_OFS_MASK;
  wire wr_feat = req.wr && req.addr == URMD_OFS_FEAT;
  wire wr_r4 = req.wr && req.addr == URMD_OFS_MODEM;
  wire wr_r5 = req.wr && req.addr == URMD_OFS_RES1;
  wire wr_r6 = req.wr && req.addr == URMD_OFS_PAUSE1;
  wire wr_r7 = req.wr && req.addr == URMD_OFS_PAUSE2;
  wire wr_line = req.wr && req.addr == URMD_OFS_LINE;
  wire wr_gplvl = req.wr && req.addr == URMD_OFS_GPLVL;
  wire wr_gpmsk = req.wr && req.addr == URMD_OFS_GPMSK;
  wire wr_pinctl = req.wr && req.addr == URMD_OFS_PINCTL;
  wire wr_extra = req.wr && req.addr == URMD_OFS_EXTRA;

  // Mask gating of the four classic sources, with fixed priority
  wire [3:0] pend = {src.modem_chg, src.line_err, src.tx_empty,
                     src.rx_ready} & mask_r[3:0]; // [RULE_02]
  // Modem status ranks last and its code is zero; bit 0 alone means none
  logic [7:0] isr_code;
  assign isr_code = pend[2] ? 8'h06 : pend[0] ? 8'h04 :
                    pend[1] ? 8'h02 : pend[3] ? 8'h00 : URMD_ISR_NONE;
  assign irq_status = isr_code;
  assign irq_n = isr_code[0];

  always_comb begin
    rdata_nxt = URMD_RST_ZERO;
    case (req.addr)
      URMD_OFS_HOLD: rdata_nxt = (map == URMD_MAP_DIVISOR) ? div_lo_r :
                                 rx_char; // [RULE_03]
      URMD_OFS_MASK: rdata_nxt = (map == URMD_MAP_DIVISOR) ? div_hi_r :
                                 mask_r;
      URMD_OFS_FEAT: begin
        if (map == URMD_MAP_ENHANCED) begin
          rdata_nxt = feat_r;
        end else if (map == URMD_MAP_DIVISOR && enh_on) begin
          rdata_nxt = frac_r;
        end else begin
          rdata_nxt = isr_code;
        end
      end
      URMD_OFS_LINE: rdata_nxt = line_r;
      URMD_OFS_MODEM: rdata_nxt = line_is_key ? res1_r : modem_r;
      URMD_OFS_RES1: rdata_nxt = line_is_key ? res2_r : URMD_RST_ZERO;
      URMD_OFS_PAUSE1: rdata_nxt = line_is_key ? pause1_r : URMD_RST_ZERO;
      URMD_OFS_PAUSE2: rdata_nxt = line_is_key ? pause2_r : URMD_RST_ZERO;
      URMD_OFS_GPLVL: rdata_nxt = gp_level_in;
      URMD_OFS_GPMSK: rdata_nxt = gpmsk_r;
      URMD_OFS_PINCTL: rdata_nxt = pinctl_r & URMD_PINCTL_MASK; // [RULE_08]
      URMD_OFS_EXTRA: rdata_nxt = extra_r & URMD_EXTRA_MASK;
      default: rdata_nxt = URMD_RST_ZERO; // [RULE_08]
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= URMD_RST_ZERO;
      rx_pop_r <= 1'b0;
    end else begin
      // Held until the next read so a slow host can fetch it at leisure
      rdata_r <= req.rd ? rdata_nxt : rdata_r;
      rx_pop_r <= req.rd && req.addr == URMD_OFS_HOLD &&
                  map != URMD_MAP_DIVISOR; // [RULE_03]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_r <= URMD_RST_ZERO;
      tx_load_r <= 1'b0;
      div_lo_r <= URMD_RST_ZERO;
      div_hi_r <= URMD_RST_ZERO;
      mask_r <= URMD_RST_ZERO;
      line_r <= URMD_RST_LINE;
    end else begin
      tx_load_r <= wr_hold && map != URMD_MAP_DIVISOR; // [RULE_04]
      if (wr_hold && map != URMD_MAP_DIVISOR) tx_r <= req.wdata;
      if (wr_hold && map == URMD_MAP_DIVISOR) div_lo_r <= req.wdata;
      if (wr_mask && map == URMD_MAP_DIVISOR) div_hi_r <= req.wdata;
      if (wr_mask && map != URMD_MAP_DIVISOR) begin
        mask_r <= urmd_merge(mask_r, req.wdata, URMD_MASK_ENH,
                             enh_on); // [RULE_01]
      end
      if (wr_line) line_r <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      feat_r <= URMD_RST_ZERO;
      frac_r <= URMD_RST_ZERO;
      qctl_r <= URMD_RST_ZERO;
      modem_r <= URMD_RST_ZERO;
      res1_r <= URMD_RST_ZERO;
      res2_r <= URMD_RST_ZERO;
      pause1_r <= URMD_RST_ZERO;
      pause2_r <= URMD_RST_ZERO;
    end else begin
      if (wr_feat && map == URMD_MAP_ENHANCED) begin
        feat_r <= req.wdata; // [RULE_06]
      end
      // Offset 2 in the divisor map stays the status port until unlocked
      if (wr_feat && map == URMD_MAP_DIVISOR && enh_on) begin
        frac_r <= req.wdata; // [RULE_01]
      end
      if (wr_feat && map == URMD_MAP_PLAIN) begin
        qctl_r <= urmd_merge(qctl_r, req.wdata, URMD_QCTL_ENH, enh_on);
      end
      if (wr_r4 && !line_is_key) begin
        modem_r <= urmd_merge(modem_r, req.wdata, URMD_MODEM_ENH,
                              enh_on); // [RULE_01]
      end
      if (wr_r4 && line_is_key) res1_r <= req.wdata; // [RULE_07]
      if (wr_r5 && line_is_key) res2_r <= req.wdata;
      if (wr_r6 && line_is_key) pause1_r <= req.wdata;
      if (wr_r7 && line_is_key) pause2_r <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gplvl_r <= URMD_RST_ZERO;
      gpmsk_r <= URMD_RST_ZERO;
      pinctl_r <= URMD_RST_ZERO;
      extra_r <= URMD_RST_ZERO;
      core_reset_r <= 1'b0;
    end else begin
      if (wr_gplvl) gplvl_r <= req.wdata;
      if (wr_gpmsk) gpmsk_r <= req.wdata;
      // Reset bit self-clears so the core sees a single pulse
      core_reset_r <= wr_pinctl &&
                      req.wdata[URMD_PINCTL_SWRST_BIT]; // [RULE_08]
      if (wr_pinctl) begin
        // Reserved bits are dropped at the door so they read back zero
        pinctl_r <= req.wdata & URMD_PINCTL_MASK; // [RULE_08]
      end
      if (wr_extra) begin
        extra_r <= req.wdata & URMD_EXTRA_MASK; // [RULE_08]
      end
    end
  end

  assign rdata = rdata_r;
  assign rx_pop = rx_pop_r;
  assign tx_char = tx_r;
  assign tx_load = tx_load_r;
  assign divisor = {div_hi_r, div_lo_r};
  assign frac_divisor = frac_r;
  assign feature = feat_r;
  assign line_control = line_r;
  assign irq_mask = mask_r;
  assign queue_control = qctl_r;
  assign modem_line_control = modem_r;
  assign flow_chars = {pause2_r, pause1_r, res2_r, res1_r};
  assign gp_level_out = gplvl_r;
  assign gp_irq_mask = gpmsk_r;
  assign pin_control = pinctl_r;
  assign extra_control = extra_r;
  assign core_reset = core_reset_r;

  cov_divisor_c: cover property (@(posedge clk) disable iff (reset)
    wr_hold && map == URMD_MAP_DIVISOR);
  cov_enh_c: cover property (@(posedge clk) disable iff (reset)
    wr_feat && map == URMD_MAP_ENHANCED);
  cov_swrst_c: cover property (@(posedge clk) disable iff (reset)
    core_reset);
  cov_frac_c: cover property (@(posedge clk) disable iff (reset)
    wr_feat && map == URMD_MAP_DIVISOR && enh_on);
  cov_irq_c: cover property (@(posedge clk) disable iff (reset)
    !irq_n);

  enh_gate_a: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    wr_mask && map == URMD_MAP_PLAIN && !enh_on
    |=> mask_r[7:4] == $past(mask_r[7:4]))
    else $error("enhanced mask bits written while locked");
  frac_gate_a: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    !enh_on |=> frac_r == $past(frac_r))
    else $error("fractional divisor changed while locked");
  irq_mask_a: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
    (pend == 4'h0) |-> irq_status == URMD_ISR_NONE)
    else $error("interrupt reported with all sources masked");
  rx_read_a: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
    req.rd && req.addr == URMD_OFS_HOLD && map == URMD_MAP_PLAIN
    |=> rdata == $past(rx_char) && rx_pop)
    else $error("holding read did not return received character");
  tx_load_a: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
    wr_hold && map != URMD_MAP_DIVISOR
    |=> tx_load && tx_char == $past(req.wdata))
    else $error("transmit character not loaded");
  div_map_a: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
    wr_hold && map == URMD_MAP_DIVISOR
    |=> divisor[7:0] == $past(req.wdata) && !tx_load)
    else $error("divisor low not written");
  flow_char_a: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
    wr_r6 && !line_is_key |=> pause1_r == $past(pause1_r))
    else $error("flow character written outside enhanced map");
  feat_map_a: assert property (@(posedge clk) disable iff (reset) // [RULE_06]
    wr_feat && map == URMD_MAP_ENHANCED |=> feature == $past(req.wdata))
    else $error("feature register not written");
  swrst_a: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
    wr_pinctl && req.wdata[URMD_PINCTL_SWRST_BIT]
    |=> core_reset ##1 (!core_reset ||
    $past(wr_pinctl && req.wdata[URMD_PINCTL_SWRST_BIT])))
    else $error("software reset pulse missing");
  swrst_src_a: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
    core_reset |-> $past(wr_pinctl && req.wdata[URMD_PINCTL_SWRST_BIT]))
    else $error("software reset pulse without a request");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
    req.rd && req.addr == URMD_OFS_RSVD |=> rdata == URMD_RST_ZERO)
    else $error("reserved offset read not zero");

  qctl_gate_a: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    wr_feat && map == URMD_MAP_PLAIN && !enh_on
    |=> queue_control[5:4] == $past(queue_control[5:4]))
    else $error("enhanced queue bits written while locked");
  modem_gate_a: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    wr_r4 && !line_is_key && !enh_on
    |=> modem_line_control[7:5] == $past(modem_line_control[7:5]))
    else $error("enhanced modem bits written while locked");

  feat_lock_a: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
    wr_feat && map != URMD_MAP_ENHANCED |=> feature == $past(feature))
    else $error("feature register written outside enhanced map");
  flow_quiet_a: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
    (wr_r4 || wr_r5 || wr_r6 || wr_r7) && !line_is_key
    |=> flow_chars == $past(flow_chars))
    else $error("flow characters changed outside enhanced map");

  div_high_a: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
    wr_mask && map == URMD_MAP_DIVISOR
    |=> divisor[15:8] == $past(req.wdata) && irq_mask == $past(irq_mask))
    else $error("divisor high not written");
  div_read_a: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
    req.rd && req.addr == URMD_OFS_HOLD && map == URMD_MAP_DIVISOR
    |=> rdata == $past(divisor[7:0]) && !rx_pop)
    else $error("divisor low not read back");
  rdata_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
    !req.rd |=> rdata == $past(rdata))
    else $error("read data changed without a read");
  irq_level_a: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
    irq_n == !(src.rx_ready && irq_mask[0] || src.tx_empty && irq_mask[1] ||
    src.line_err && irq_mask[2] || src.modem_chg && irq_mask[3]))
    else $error("interrupt line disagrees with enabled sources");
endmodule

// ==== urmd_host.sv ====
`timescale 1ns/10ps
module urmd_host (
  input wire logic clk,
  output urmd_pkg::urmd_req_s req,
  input wire logic [7:0] rdata
);
  import urmd_pkg::*;
  logic [7:0] last_r;
  initial begin
    req = '0;
    last_r = 8'h00;
  end
  // One-cycle strobe; data flips after it so a stale byte never looks valid
  task automatic access(input logic [3:0] a, input logic w,
                        input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    req.wdata <= ~d;
    #1;
    if (!w) begin
      last_r = rdata;
    end
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import urmd_pkg::*;
  logic clk, reset, rx_pop, tx_load, irq_n, core_reset;
  urmd_req_s req;
  urmd_src_s src;
  logic [7:0] rdata, rx_char, tx_char, irq_status, frac_divisor, feature;
  logic [7:0] gp_level_in;
  logic [7:0] line_control, irq_mask, queue_control, modem_line_control;
  logic [7:0] gp_level_out, gp_irq_mask, pin_control, extra_control;
  logic [15:0] divisor;
  logic [31:0] flow_chars;
  logic [7:0] code [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
  int n_errors = 0;
  int tests_run = 0;
  urmd_regs dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .rx_char(rx_char), .rx_pop(rx_pop), .tx_char(tx_char),
    .tx_load(tx_load), .src(src), .irq_status(irq_status), .irq_n(irq_n),
    .divisor(divisor), .frac_divisor(frac_divisor), .feature(feature),
    .line_control(line_control), .irq_mask(irq_mask),
    .queue_control(queue_control),
    .modem_line_control(modem_line_control), .flow_chars(flow_chars),
    .gp_level_out(gp_level_out), .gp_level_in(gp_level_in),
    .gp_irq_mask(gp_irq_mask), .pin_control(pin_control),
    .extra_control(extra_control), .core_reset(core_reset));
  urmd_host host (.clk(clk), .req(req), .rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.access(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    host.access(a, 1'b0, 8'h00);
    chk(host.last_r, e);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    rx_char = 8'ha5;
    src = '0;
    gp_level_in = 8'h3c;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_chk(URMD_OFS_LINE, URMD_RST_LINE);
    rd_chk(URMD_OFS_GPLVL, 8'h3c);
    wr(URMD_OFS_GPLVL, 8'h5a);
    chk(gp_level_out, 8'h5a);
    wr(URMD_OFS_GPMSK, 8'hc3);
    rd_chk(URMD_OFS_GPMSK, 8'hc3);
    chk(gp_irq_mask, 8'hc3);
    wr(URMD_OFS_RSVD, 8'hff);
    rd_chk(URMD_OFS_RSVD, 8'h00);
    wr(URMD_OFS_EXTRA, 8'hff);
    rd_chk(URMD_OFS_EXTRA, URMD_EXTRA_MASK);
    wr(URMD_OFS_PINCTL, 8'h0b);
    chk(core_reset, 1'b1);
    rd_chk(URMD_OFS_PINCTL, 8'h03);
    chk({pin_control, extra_control}, {8'h03, URMD_EXTRA_MASK});
    $display("test reset_and_reserved done");
    wr(URMD_OFS_HOLD, 8'h55);
    chk({tx_load, tx_char}, {1'b1, 8'h55});
    rd_chk(URMD_OFS_HOLD, 8'ha5);
    chk(rx_pop, 1'b1);
    $display("test holding done");
    wr(URMD_OFS_LINE, 8'h83);
    wr(URMD_OFS_HOLD, 8'h34);
    chk(tx_load, 1'b0);
    wr(URMD_OFS_MASK, 8'h12);
    chk(divisor, 16'h1234);
    rd_chk(URMD_OFS_HOLD, 8'h34);
    chk(rx_pop, 1'b0);
    wr(URMD_OFS_FEAT, 8'h0f);
    chk(frac_divisor, 8'h00);
    wr(URMD_OFS_LINE, 8'h03);
    wr(URMD_OFS_MASK, 8'hff);
    rd_chk(URMD_OFS_MASK, 8'h0f);
    chk({line_control, irq_mask}, 16'h030f);
    wr(URMD_OFS_FEAT, 8'hff);
    chk(queue_control, 8'hcf);
    rd_chk(URMD_OFS_FEAT, URMD_ISR_NONE);
    wr(URMD_OFS_MODEM, 8'hff);
    chk(modem_line_control, 8'h1f);
    $display("test divisor done");
    wr(URMD_OFS_LINE, URMD_LINE_ENH_KEY);
    wr(URMD_OFS_FEAT, 8'hd5);
    chk(feature, 8'hd5);
    for (int i = 4; i < 8; i++) begin
      wr(4'(i), 8'(16 * i + 1));
    end
    chk(flow_chars, 32'h71615141);
    rd_chk(URMD_OFS_PAUSE2, 8'h71);
    wr(URMD_OFS_HOLD, 8'h99);
    chk(divisor, 16'h1234);
    wr(URMD_OFS_LINE, 8'h80);
    wr(URMD_OFS_FEAT, 8'h0f);
    chk(frac_divisor, 8'h0f);
    rd_chk(URMD_OFS_FEAT, 8'h0f);
    wr(URMD_OFS_LINE, 8'h03);
    wr(URMD_OFS_MODEM, 8'h0e);
    chk(modem_line_control, 8'h0e);
    wr(URMD_OFS_PAUSE1, 8'haa);
    rd_chk(URMD_OFS_PAUSE1, 8'h00);
    chk(flow_chars, 32'h71615141);
    wr(URMD_OFS_FEAT, 8'hff);
    chk(queue_control, 8'hff);
    @(posedge clk);
    rx_char <= 8'h3e;
    rd_chk(URMD_OFS_HOLD, 8'h3e);
    wr(URMD_OFS_MASK, 8'hff);
    rd_chk(URMD_OFS_MASK, 8'hff);
    $display("test enhanced done");
    // Each source alone, first masked off, then enabled by its own bit
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src <= urmd_src_s'(4'(8 >> i));
      wr(URMD_OFS_MASK, 8'h00);
      chk({irq_n, irq_status}, {1'b1, URMD_ISR_NONE});
      wr(URMD_OFS_MASK, 8'(1 << i));
      chk({irq_n, irq_status}, {1'b0, code[i]});
    end
    $display("test irq_gating done");
    final_report();
  end
endmodule
